/* File: src/reset_source_and_init_control.sv */
// Reset source handling, reset flags and initial state control.
// Function
// - Programming key 55h write resets whole device
// - Run-mode watchdog timeout: reset, set expiry flag
// - Sleep/idle timeout: clear PC, SP, set flags
// - Power-on or deep-sleep wake clears both flags
// - Low-voltage reset keeps both flags unchanged
// - Flags live in status, updated by events
// - Power-on reset disables all interrupts
// - Full reset clears watchdog, time bases; warm reset clears watchdog only; watchdog restarts
// - Power-on reset turns timer modules off
// - Power-on reset makes port pins inputs
// - PC zero; SP at stack top on full reset, zero on warm reset
// - Serial/UART registers share addresses via select bit
// - Bad reset key value resets after delay
`timescale 1ns/1ps
module reset_source_and_init_control (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic wdt_timeout,
	input wire logic low_voltage_reset,
	input wire logic deep_wake,
	input wire logic halt_enter,
	input wire logic [1:0] run_mode,
	output logic sys_reset,
	output logic core_reset,
	output logic [7:0] pc_init,
	output logic [2:0] sp_init,
	output logic wdt_clear,
	output logic timebase_clear,
	output logic [7:0] int_enable,
	output logic [7:0] timer_enable,
	output logic [7:0] port_dir_in,
	output logic watchdog_expiry_flag,
	output logic powerdown_flag
);
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_n;
	logic wdt_s;
	logic lowv_s;
	logic wake_s;
	logic wdt_prev_q;
	logic lowv_prev_q;
	logic wake_prev_q;
	logic wdt_ev;
	logic lowv_ev;
	logic wake_ev;
	rst_pkg::reg_req_t req;
	rst_pkg::rst_kind_t kind_d;
	logic prog_hit;
	logic [7:0] prog_ctrl2_q;
	logic [7:0] prog_ctrl2_d;
	logic [7:0] key_q;
	logic [7:0] key_d;
	logic to_q;
	logic to_d;
	logic pwrdn_q;
	logic pwrdn_d;
	logic swrst_q;
	logic swrst_d;
	logic [7:0] int_en_q;
	logic [7:0] int_en_d;
	logic [7:0] tmr_en_q;
	logic [7:0] tmr_en_d;
	logic [7:0] dir_q;
	logic [7:0] dir_d;
	logic uart_sel_q;
	logic uart_sel_d;
	logic [7:0] ser_c1_q;
	logic [7:0] ser_c1_d;
	logic [7:0] uart_c1_q;
	logic [7:0] uart_c1_d;
	logic [7:0] ser_to_q;
	logic [7:0] ser_to_d;
	logic [7:0] baud_q;
	logic [7:0] baud_d;
	logic [4:0] dly_q;
	logic [4:0] dly_d;
	logic dly_run_q;
	logic dly_run_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	rst_pkg::core_init_t core_q;
	rst_pkg::core_init_t core_d;
	logic full_req;
	logic warm_req;
	logic full_pulse;
	logic warm_pulse;
	logic key_bad;
	logic lowpower;

	// Release the external reset through two flip-flops.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	rst_sync3 u_sync_wdt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din(wdt_timeout),
		.dout(wdt_s)
	);
	rst_sync3 u_sync_lowv (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din(low_voltage_reset),
		.dout(lowv_s)
	);
	rst_sync3 u_sync_wake (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din(deep_wake),
		.dout(wake_s)
	);

	assign wdt_ev = wdt_s & ~wdt_prev_q;
	assign lowv_ev = lowv_s & ~lowv_prev_q;
	assign wake_ev = wake_s & ~wake_prev_q;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign lowpower = (run_mode == rst_pkg::MODE_IDLE) ||
		(run_mode == rst_pkg::MODE_SLEEP);
	assign key_bad = (key_q != rst_pkg::RSTKEY_NOP_A) &&
		(key_q != rst_pkg::RSTKEY_NOP_B);
	assign prog_hit = req.wr && req.addr == rst_pkg::OFS_PROG_CTRL2 &&
		req.wdata == rst_pkg::PROG_RESET_KEY;

	// Reset requests from every source except the external reset pin are classified in one place.
	always_comb begin
		full_req = 1'b0;
		warm_req = 1'b0;
		kind_d = rst_pkg::RS_NONE;
		if (prog_hit) begin
			full_req = 1'b1;
			kind_d = rst_pkg::RS_FULL;
		end else if (dly_run_q && dly_q == 5'h0) begin
			full_req = 1'b1;
			kind_d = rst_pkg::RS_FULL;
		end else if (wdt_ev && !lowpower) begin
			full_req = 1'b1;
			kind_d = rst_pkg::RS_FULL;
		end else if (wdt_ev) begin
			warm_req = 1'b1;
			kind_d = rst_pkg::RS_WARM;
		end else if (lowv_ev && !lowpower) begin
			full_req = 1'b1;
			kind_d = rst_pkg::RS_LOWV;
		end else if (wake_ev) begin
			full_req = 1'b1;
			kind_d = rst_pkg::RS_DEEP;
		end
	end

	rst_pulse u_full (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.req(full_req),
		.pulse(full_pulse)
	);
	rst_pulse u_warm (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.req(warm_req),
		.pulse(warm_pulse)
	);

	// Register file and reset effects on the controlled state.
	always_comb begin
		prog_ctrl2_d = prog_ctrl2_q;
		key_d = key_q;
		to_d = to_q;
		pwrdn_d = pwrdn_q;
		swrst_d = swrst_q;
		int_en_d = int_en_q;
		tmr_en_d = tmr_en_q;
		dir_d = dir_q;
		uart_sel_d = uart_sel_q;
		ser_c1_d = ser_c1_q;
		uart_c1_d = uart_c1_q;
		ser_to_d = ser_to_q;
		baud_d = baud_q;
		core_d = core_q;
		dly_d = dly_q;
		dly_run_d = dly_run_q;
		if (req.wr) begin
			case (req.addr)
				rst_pkg::OFS_PROG_CTRL2: prog_ctrl2_d = req.wdata;
				rst_pkg::OFS_RESET_KEY: key_d = req.wdata;
				rst_pkg::OFS_FLAGS: begin
					// Software may only clear the flag.
					if (!req.wdata[rst_pkg::FLAG_SWRST_BIT]) begin
						swrst_d = 1'b0;
					end
				end
				rst_pkg::OFS_INT_EN: int_en_d = req.wdata;
				rst_pkg::OFS_TIMER_EN: tmr_en_d = req.wdata;
				rst_pkg::OFS_PORT_DIR: dir_d = req.wdata;
				rst_pkg::OFS_SER_CTRL1: begin
					if (uart_sel_q) begin
						uart_c1_d = req.wdata;
					end else begin
						ser_c1_d = req.wdata;
					end
				end
				rst_pkg::OFS_SER_TOUT: begin
					if (uart_sel_q) begin
						baud_d = req.wdata;
					end else begin
						ser_to_d = req.wdata;
					end
				end
				rst_pkg::OFS_SER_MODE: uart_sel_d = req.wdata[0];
				default: begin
				end
			endcase
		end
		// A corrupted key starts the delayed reset once.
		if (key_bad && !dly_run_q) begin
			dly_run_d = 1'b1;
			dly_d = rst_pkg::SRESET_CNT;
		end else if (dly_run_q && dly_q != 5'h0) begin
			dly_d = dly_q - 5'h1;
		end
		if (halt_enter) begin
			pwrdn_d = 1'b1;
		end
		// Reset effects land last so they win over software writes.
		case (kind_d)
			rst_pkg::RS_FULL, rst_pkg::RS_LOWV, rst_pkg::RS_DEEP: begin
				prog_ctrl2_d = 8'h00;
				key_d = rst_pkg::RSTKEY_POR;
				dly_run_d = 1'b0;
				dly_d = 5'h0;
				int_en_d = rst_pkg::INT_EN_RST;
				tmr_en_d = rst_pkg::TIMER_EN_RST;
				dir_d = rst_pkg::PORT_DIR_RST;
				uart_sel_d = 1'b0;
				ser_c1_d = rst_pkg::SER_CTRL1_RST;
				uart_c1_d = rst_pkg::UART_CTRL1_RST;
				ser_to_d = rst_pkg::SER_TOUT_RST;
				baud_d = rst_pkg::UART_BAUD_RST;
				core_d.pc = rst_pkg::PC_RST;
				core_d.sp = rst_pkg::SP_TOP;
				if (dly_run_q && dly_q == 5'h0) begin
					swrst_d = 1'b1;
				end
				if (kind_d == rst_pkg::RS_DEEP) begin
					to_d = 1'b0;
					pwrdn_d = 1'b0;
				end else if (kind_d == rst_pkg::RS_FULL && wdt_ev &&
					!(dly_run_q && dly_q == 5'h0) && !prog_hit) begin
					to_d = 1'b1;
				end
			end
			rst_pkg::RS_WARM: begin
				core_d.pc = rst_pkg::PC_RST;
				core_d.sp = 3'h0;
				to_d = 1'b1;
				pwrdn_d = 1'b1;
			end
			default: begin
			end
		endcase
	end

	// Read data stand in the cycle after the read strobe.
	always_comb begin
		rdata_d = 8'h00;
		if (req.rd) begin
			case (req.addr)
				rst_pkg::OFS_PROG_CTRL2: rdata_d = prog_ctrl2_q;
				rst_pkg::OFS_RESET_KEY: rdata_d = key_q;
				rst_pkg::OFS_STATUS: begin
					rdata_d[rst_pkg::STAT_TO_BIT] = to_q;
					rdata_d[rst_pkg::STAT_PWRDN_BIT] = pwrdn_q;
				end
				rst_pkg::OFS_FLAGS: rdata_d[rst_pkg::FLAG_SWRST_BIT] = swrst_q;
				rst_pkg::OFS_INT_EN: rdata_d = int_en_q;
				rst_pkg::OFS_TIMER_EN: rdata_d = tmr_en_q;
				rst_pkg::OFS_PORT_DIR: rdata_d = dir_q;
				rst_pkg::OFS_SER_CTRL1:
					rdata_d = uart_sel_q ? uart_c1_q : ser_c1_q;
				rst_pkg::OFS_SER_TOUT:
					rdata_d = uart_sel_q ? baud_q : ser_to_q;
				rst_pkg::OFS_SER_MODE: rdata_d = {7'h00, uart_sel_q};
				rst_pkg::OFS_CORE: rdata_d = core_q.pc;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_prev_q <= 1'b0;
			lowv_prev_q <= 1'b0;
			wake_prev_q <= 1'b0;
			prog_ctrl2_q <= 8'h00;
			key_q <= rst_pkg::RSTKEY_POR;
			to_q <= 1'b0;
			pwrdn_q <= 1'b0;
			swrst_q <= 1'b0;
			int_en_q <= rst_pkg::INT_EN_RST;
			tmr_en_q <= rst_pkg::TIMER_EN_RST;
			dir_q <= rst_pkg::PORT_DIR_RST;
			uart_sel_q <= 1'b0;
			ser_c1_q <= rst_pkg::SER_CTRL1_RST;
			uart_c1_q <= rst_pkg::UART_CTRL1_RST;
			ser_to_q <= rst_pkg::SER_TOUT_RST;
			baud_q <= rst_pkg::UART_BAUD_RST;
			core_q <= '{pc: rst_pkg::PC_RST, sp: rst_pkg::SP_TOP};
			dly_q <= 5'h0;
			dly_run_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			wdt_prev_q <= wdt_s;
			lowv_prev_q <= lowv_s;
			wake_prev_q <= wake_s;
			prog_ctrl2_q <= prog_ctrl2_d;
			key_q <= key_d;
			to_q <= to_d;
			pwrdn_q <= pwrdn_d;
			swrst_q <= swrst_d;
			int_en_q <= int_en_d;
			tmr_en_q <= tmr_en_d;
			dir_q <= dir_d;
			uart_sel_q <= uart_sel_d;
			ser_c1_q <= ser_c1_d;
			uart_c1_q <= uart_c1_d;
			ser_to_q <= ser_to_d;
			baud_q <= baud_d;
			core_q <= core_d;
			dly_q <= dly_d;
			dly_run_q <= dly_run_d;
			rdata_q <= rdata_d;
		end
	end

	// The power-up reset also counts as a full reset toward peripherals.
	assign sys_reset = full_pulse | ~rst_n;
	assign core_reset = warm_pulse | full_pulse | ~rst_n;
	assign wdt_clear = sys_reset | warm_pulse;
	assign timebase_clear = sys_reset;
	assign pc_init = core_q.pc;
	assign sp_init = core_q.sp;
	assign int_enable = int_en_q;
	assign timer_enable = tmr_en_q;
	assign port_dir_in = dir_q;
	assign watchdog_expiry_flag = to_q;
	assign powerdown_flag = pwrdn_q;
	assign reg_rdata = rdata_q;
endmodule

/* File: src/rst_pkg.sv */
// Package with constants, types and register map of the reset controller.
package rst_pkg;

	localparam logic [7:0] PROG_RESET_KEY = 8'h55;
	localparam logic [7:0] RSTKEY_NOP_A = 8'h55;
	localparam logic [7:0] RSTKEY_NOP_B = 8'haa;
	localparam logic [7:0] RSTKEY_POR = 8'h55;

	// Register offsets on the plain register port.
	localparam logic [3:0] OFS_PROG_CTRL2 = 4'h0;
	localparam logic [3:0] OFS_RESET_KEY = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_FLAGS = 4'h3;
	localparam logic [3:0] OFS_INT_EN = 4'h4;
	localparam logic [3:0] OFS_TIMER_EN = 4'h5;
	localparam logic [3:0] OFS_PORT_DIR = 4'h6;
	localparam logic [3:0] OFS_SER_CTRL1 = 4'h7;
	localparam logic [3:0] OFS_SER_TOUT = 4'h8;
	localparam logic [3:0] OFS_SER_MODE = 4'h9;
	localparam logic [3:0] OFS_CORE = 4'ha;

	// Status and flags register bit positions.
	localparam int STAT_PWRDN_BIT = 4;
	localparam int STAT_TO_BIT = 5;
	localparam int FLAG_SWRST_BIT = 3;

	// Reset values.
	localparam logic [7:0] INT_EN_RST = 8'h00;
	localparam logic [7:0] TIMER_EN_RST = 8'h00;
	localparam logic [7:0] PORT_DIR_RST = 8'hff;
	localparam logic [7:0] SER_CTRL1_RST = 8'h81;
	localparam logic [7:0] UART_CTRL1_RST = 8'h00;
	localparam logic [7:0] SER_TOUT_RST = 8'h00;
	localparam logic [7:0] UART_BAUD_RST = 8'h00;
	localparam logic [7:0] PC_RST = 8'h00;
	localparam logic [2:0] SP_TOP = 3'h7;

	// Delay before a key-register reset fires, in ns and in cycles.
	localparam int CLK_PERIOD_NS = 4;
	localparam int SRESET_DELAY_NS = 64;
	localparam int SRESET_CYC = (SRESET_DELAY_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [4:0] SRESET_CNT = 5'(SRESET_CYC);
	// Length of a generated internal reset pulse in cycles.
	localparam logic [2:0] PULSE_CNT = 3'h4;

	typedef enum logic [1:0] {
		MODE_FAST = 2'h0,
		MODE_SLOW = 2'h1,
		MODE_IDLE = 2'h2,
		MODE_SLEEP = 2'h3
	} run_mode_t;

	typedef enum logic [4:0] {
		RS_NONE = 5'h01,
		RS_FULL = 5'h02,
		RS_WARM = 5'h04,
		RS_LOWV = 5'h08,
		RS_DEEP = 5'h10
	} rst_kind_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] pc;
		logic [2:0] sp;
	} core_init_t;

endpackage

/* File: src/rst_sync3.sv */
// Three-stage synchroniser with agreement filter for asynchronous events.
`timescale 1ns/1ps
module rst_sync3 (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic out_q;
	logic out_d;

	always_comb begin
		sh_d = {sh_q[1:0], din};
		// The first stage is only seen by the second.
		out_d = (sh_q[2] == sh_q[1]) ? sh_q[1] : out_q;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_q <= 3'h0;
			out_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule

/* File: src/rst_pulse.sv */
// Stretcher that turns a reset request into a synchronous pulse.
`timescale 1ns/1ps
module rst_pulse (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req,
	output logic pulse
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;

	always_comb begin
		if (req) begin
			cnt_d = rst_pkg::PULSE_CNT;
		end else if (cnt_q != 3'h0) begin
			cnt_d = cnt_q - 3'h1;
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign pulse = (cnt_q != 3'h0);
endmodule

/* File: sim/reset_source_and_init_control_properties.sv */
// Concurrent checks on the reset controller ports.
`timescale 1ns/1ps
module reset_source_and_init_control_properties (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sys_reset,
	input wire logic core_reset,
	input wire logic [7:0] pc_init,
	input wire logic [2:0] sp_init,
	input wire logic wdt_clear,
	input wire logic timebase_clear,
	input wire logic [7:0] int_enable,
	input wire logic [7:0] timer_enable,
	input wire logic [7:0] port_dir_in,
	input wire logic watchdog_expiry_flag,
	input wire logic powerdown_flag
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_prog_key_reset:
	assert property (reg_wr && reg_addr == rst_pkg::OFS_PROG_CTRL2 &&
		reg_wdata == rst_pkg::PROG_RESET_KEY |=> sys_reset)
	else $error("key write gave no reset");
	a_sys_pulse_len:
	assert property ($rose(sys_reset) |-> sys_reset[*4])
	else $error("full reset pulse too short");
	a_core_pulse_len:
	assert property ($rose(core_reset) |-> core_reset[*4])
	else $error("core reset pulse too short");
	a_core_with_sys:
	assert property (sys_reset |-> core_reset)
	else $error("full reset without core reset");
	a_init_state:
	assert property ($fell(sys_reset) |-> int_enable == 8'h00 &&
		timer_enable == 8'h00 && port_dir_in == 8'hff)
	else $error("wrong state after reset");
	a_pc_zero:
	assert property ($fell(core_reset) |-> pc_init == rst_pkg::PC_RST)
	else $error("program counter not zero");
	a_sp_top:
	assert property ($fell(sys_reset) |-> sp_init == rst_pkg::SP_TOP)
	else $error("stack pointer not at top");
	a_warm_flags:
	assert property ($fell(core_reset) && !$past(sys_reset) |->
		watchdog_expiry_flag && powerdown_flag && sp_init == 3'h0)
	else $error("warm reset flags or stack wrong");
	a_clear_strobes:
	assert property (core_reset |-> wdt_clear &&
		timebase_clear == sys_reset)
	else $error("counters not cleared in reset");
	a_key_delay:
	assert property (reg_wr && reg_addr == rst_pkg::OFS_RESET_KEY &&
		!sys_reset && reg_wdata != rst_pkg::RSTKEY_NOP_A &&
		reg_wdata != rst_pkg::RSTKEY_NOP_B |=>
		(!sys_reset)[*8] ##[1:40] sys_reset)
	else $error("bad key reset timing wrong");
	a_status_read:
	assert property (reg_rd && reg_addr == rst_pkg::OFS_STATUS |=>
		reg_rdata[rst_pkg::STAT_TO_BIT] == $past(watchdog_expiry_flag) &&
		reg_rdata[rst_pkg::STAT_PWRDN_BIT] == $past(powerdown_flag))
	else $error("status read does not show flags");
endmodule
bind reset_source_and_init_control reset_source_and_init_control_properties
	chk (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .sys_reset, .core_reset, .pc_init, .sp_init, .wdt_clear,
	.timebase_clear, .int_enable, .timer_enable, .port_dir_in,
	.watchdog_expiry_flag, .powerdown_flag);

/* File: sim/reset_source_and_init_control_tb.sv */
// Self-checking bench for the reset source and init controller.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module reset_source_and_init_control_tb;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic wdt_timeout = 1'b0;
	logic low_voltage_reset = 1'b0;
	logic deep_wake = 1'b0;
	logic halt_enter = 1'b0;
	logic [1:0] run_mode = 2'h0;
	logic [7:0] reg_rdata, pc_init, int_enable, timer_enable, port_dir_in;
	logic [2:0] sp_init;
	logic sys_reset, core_reset, wdt_clear, timebase_clear;
	logic watchdog_expiry_flag, powerdown_flag;
	int n_fail = 0;
	int checked = 0;
	int lat;
	logic [31:0] seed = 32'hcc88b04b;
	logic [15:0] q[$];
	logic [15:0] ent;
	logic rd_q = 1'b0;
	logic [7:0] r;

	always #2 ref_clk = ~ref_clk;

	reset_source_and_init_control dut (.ref_clk, .reset_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wdt_timeout,
		.low_voltage_reset,
		.deep_wake, .halt_enter, .run_mode, .sys_reset, .core_reset,
		.pc_init, .sp_init, .wdt_clear, .timebase_clear, .int_enable,
		.timer_enable, .port_dir_in, .watchdog_expiry_flag,
		.powerdown_flag);

	// Read data stand one cycle only, so each read note is used once.
	always @(posedge ref_clk) begin
		if (rd_q) begin
			ent = q.pop_front();
			`CHK(reg_rdata & ent[7:0], ent[15:8])
		end
		rd_q <= reg_rd;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic summarize();
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		@(posedge ref_clk);
		q.push_back({e & m, m});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic halt();
		@(posedge ref_clk);
		halt_enter <= 1'b1;
		@(posedge ref_clk);
		halt_enter <= 1'b0;
	endtask

	task automatic mess();
		r = 8'(rnd());
		wr(rst_pkg::OFS_INT_EN, r);
		wr(rst_pkg::OFS_TIMER_EN, r);
		wr(rst_pkg::OFS_PORT_DIR, ~r);
	endtask

	task automatic rd_init();
		rd(rst_pkg::OFS_INT_EN, 8'h00);
		rd(rst_pkg::OFS_TIMER_EN, 8'h00);
		rd(rst_pkg::OFS_PORT_DIR, 8'hff);
		rd(rst_pkg::OFS_CORE, 8'h00);
	endtask

	// Sampled at the falling edge so the pulse width is never raced.
	task automatic wait_rst(input bit core, output int l);
		int n;
		int w;
		int t;
		bit s;
		n = 0;
		w = 0;
		t = 0;
		s = 0;
		l = 0;
		@(negedge ref_clk);
		while (!(core ? core_reset : sys_reset) && l < 60) begin
			@(negedge ref_clk);
			l++;
		end
		while ((core ? core_reset : sys_reset) && n < 20) begin
			s |= sys_reset;
			w += wdt_clear;
			t += timebase_clear;
			n++;
			@(negedge ref_clk);
		end
		`CHK(n, 4)
		`CHK(s, !core)
		`CHK(w, 4)
		`CHK(t, core ? 0 : 4)
		repeat (3) @(posedge ref_clk);
	endtask

	// The event line drops before the pulse ends, so only one edge is seen.
	task automatic ev(input int k, input bit core);
		@(posedge ref_clk);
		if (k == 0)
			wdt_timeout <= 1'b1;
		else if (k == 1)
			low_voltage_reset <= 1'b1;
		else
			deep_wake <= 1'b1;
		fork
			begin
				repeat (6) @(posedge ref_clk);
				wdt_timeout <= 1'b0;
				low_voltage_reset <= 1'b0;
				deep_wake <= 1'b0;
			end
			begin
				// An unused-offset write is taken with the event edge.
				repeat (4) @(posedge ref_clk);
				reg_addr <= 4'hb;
				reg_wr <= 1'b1;
				@(posedge ref_clk);
				reg_wr <= 1'b0;
			end
			wait_rst(core, lat);
		join
	endtask

	initial begin
		#20000;
		n_fail++;
		summarize();
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rd_init();
		rd(rst_pkg::OFS_RESET_KEY, 8'h55);
		rd(rst_pkg::OFS_STATUS, 8'h00, 8'h30);
		`CHK(sp_init, rst_pkg::SP_TOP)
		rd(rst_pkg::OFS_SER_CTRL1, 8'h81);
		rd(rst_pkg::OFS_SER_TOUT, 8'h00);
		rd(4'hb, 8'h00);
		wr(4'hb, 8'h5a);
		rd(4'hb, 8'h00);
		wr(rst_pkg::OFS_SER_MODE, 8'h01);
		rd(rst_pkg::OFS_SER_CTRL1, rst_pkg::UART_CTRL1_RST);
		rd(rst_pkg::OFS_SER_TOUT, rst_pkg::UART_BAUD_RST);
		mess();
		wr(rst_pkg::OFS_PROG_CTRL2, 8'h55);
		wait_rst(1'b0, lat);
		`CHK(lat, 0)
		rd_init();
		halt();
		rd(rst_pkg::OFS_STATUS, 8'h10, 8'h30);
		mess();
		ev(0, 1'b0);
		rd(rst_pkg::OFS_STATUS, 8'h30, 8'h30);
		rd_init();
		@(posedge ref_clk);
		run_mode <= 2'h1;
		ev(1, 1'b0);
		rd(rst_pkg::OFS_STATUS, 8'h30, 8'h30);
		for (int m = 2; m < 4; m++) begin
			@(posedge ref_clk);
			run_mode <= 2'(m);
			ev(2, 1'b0);
			rd(rst_pkg::OFS_STATUS, 8'h00, 8'h30);
			mess();
			ev(0, 1'b1);
			rd(rst_pkg::OFS_STATUS, 8'h30, 8'h30);
			rd(rst_pkg::OFS_INT_EN, r);
			`CHK(sp_init, 3'h0)
		end
		@(posedge ref_clk);
		run_mode <= 2'h0;
		wr(rst_pkg::OFS_RESET_KEY, 8'haa);
		lat = 0;
		repeat (30) begin
			@(negedge ref_clk);
			if (sys_reset !== 1'b0)
				lat++;
		end
		`CHK(lat, 0)
		r = 8'(rnd());
		if (r == 8'h55 || r == 8'haa)
			r = 8'h12;
		wr(rst_pkg::OFS_RESET_KEY, r);
		wait_rst(1'b0, lat);
		`CHK(lat >= 12 && lat <= 22, 1'b1)
		rd(rst_pkg::OFS_FLAGS, 8'h08, 8'h08);
		wr(rst_pkg::OFS_FLAGS, 8'h00);
		rd(rst_pkg::OFS_FLAGS, 8'h00, 8'h08);
		rd(rst_pkg::OFS_RESET_KEY, 8'h55);
		repeat (3) @(posedge ref_clk);
		summarize();
	end
endmodule
